// File: hw/ctb_pkg.sv
// Operation
// - Free-running 16-bit counter, read as two bytes
// - One shared count for all five modules
// - Twelve-clock sources: /12, /4, timer0, external
// - Six-clock mode uses /6 and /2 instead
// - Mode byte: source bits 2:1, irq enable bit 0
// - Counter advances only while run bit set
// - Counter wrap sets overflow flag bit 7
// - Overflow interrupt only when its enable set
// - Overflow flag cleared only by software
// - Each module sets its own event flag
// - Module event flags cleared only by software
// - Timer0 overflows counted regardless of its interrupt
// - Only module four offers the watchdog function
// - Modules zero to four use port bits 3-7
// - Unused module pins stay general purpose
// - External count enters on port bit 2
// - Module flag interrupts gated by per-module enable
package ctb_pkg;

  localparam int unsigned NUM_MODULES = 5;
  localparam int unsigned PORT_W      = 6;
  localparam int unsigned ADR_W       = 6;
  localparam int unsigned WB_DATA_W   = 32;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_MODE      = 6'h00;
  localparam logic [ADR_W-1:0] OFS_CTRL      = 6'h04;
  localparam logic [ADR_W-1:0] OFS_CNT_LO    = 6'h08;
  localparam logic [ADR_W-1:0] OFS_CNT_HI    = 6'h0C;
  localparam logic [ADR_W-1:0] OFS_EV_IRQ_EN = 6'h10;
  localparam logic [ADR_W-1:0] OFS_CLK_CFG   = 6'h14;
  localparam logic [ADR_W-1:0] OFS_PORT_OUT  = 6'h18;
  localparam logic [ADR_W-1:0] OFS_PORT_DIR  = 6'h1C;
  localparam logic [ADR_W-1:0] OFS_PORT_IN   = 6'h20;

  // Field positions
  localparam int unsigned MODE_IRQ_EN_BIT = 0;
  localparam int unsigned MODE_SEL_LSB    = 1;
  localparam int unsigned CTRL_RUN_BIT    = 6;
  localparam int unsigned CTRL_OVF_BIT    = 7;
  localparam int unsigned CLK_SIX_BIT     = 0;
  localparam int unsigned EXT_PIN_IDX     = 0;
  localparam int unsigned MOD0_PIN_IDX    = 1;

  // Reset values and counter maximum
  localparam logic [2:0]             RST_MODE = 3'h0;
  localparam logic [15:0]            RST_CNT  = 16'h0000;
  localparam logic [NUM_MODULES-1:0] RST_FLAG = 5'h00;
  localparam logic [PORT_W-1:0]      RST_PORT = 6'h00;
  localparam logic [15:0]            CNT_MAX  = 16'hFFFF;

  // Watchdog capability, module four only
  localparam logic [NUM_MODULES-1:0] WDT_CAPABLE = 5'h10;

  // Oscillator divisors
  localparam logic [3:0] DIV12_SLOW = 4'hC;
  localparam logic [3:0] DIV12_FAST = 4'h4;
  localparam logic [3:0] DIV6_SLOW  = 4'h6;
  localparam logic [3:0] DIV6_FAST  = 4'h2;

  typedef enum logic [1:0] {
    SRC_OSC_SLOW = 2'b00,
    SRC_OSC_FAST = 2'b01,
    SRC_T0_OVF   = 2'b10,
    SRC_EXT      = 2'b11
  } ctb_src_e;

  function automatic logic adr_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
    return adr[ADR_W-1:2] == ofs[ADR_W-1:2];
  endfunction

endpackage

// File: hw/ctb_tick_if.sv
`timescale 1ns/1ps
interface ctb_tick_if;
  import ctb_pkg::*;
  ctb_src_e sel;
  logic     six_clock;
  logic     t0_ovf;
  logic     ext_fall;
  logic     tick;
  modport gen  (input sel, input six_clock, input t0_ovf, input ext_fall, output tick);
  modport user (output sel, output six_clock, output t0_ovf, output ext_fall, input tick);
endinterface // ctb_tick_if

// File: hw/ctb_pin_sync.sv
`timescale 1ns/1ps
module ctb_pin_sync
  import ctb_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Pins and results
  input  wire logic [PORT_W-1:0] pin_i,
  output logic      [PORT_W-1:0] pin_sync_o,
  output logic                   ext_fall_o
);

  logic [PORT_W-1:0] meta_reg;
  logic [PORT_W-1:0] sync_reg;
  logic              ext_prev_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RST_PORT;
      sync_reg <= RST_PORT;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  // Edge seen only on the settled copy
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= sync_reg[EXT_PIN_IDX];
    end
  end

  assign pin_sync_o = sync_reg;
  assign ext_fall_o = ext_prev_reg & ~sync_reg[EXT_PIN_IDX];

endmodule // ctb_pin_sync

// File: hw/ctb_tick_gen.sv
`timescale 1ns/1ps
module ctb_tick_gen
  import ctb_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Tick source
  ctb_tick_if.gen   tif
);

  logic [3:0] div_cnt_reg;
  logic [3:0] div_cnt_next;
  logic [3:0] divisor;
  logic       div_wrap;
  logic       tick_reg;
  logic       tick_next;

  always_comb begin
    if (tif.sel == SRC_OSC_SLOW) begin
      divisor = tif.six_clock ? DIV6_SLOW : DIV12_SLOW;
    end else begin
      divisor = tif.six_clock ? DIV6_FAST : DIV12_FAST;
    end
    div_wrap     = div_cnt_reg >= (divisor - 4'h1);
    div_cnt_next = div_wrap ? 4'h0 : div_cnt_reg + 4'h1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_reg <= 4'h0;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  always_comb begin
    unique case (tif.sel)
      SRC_OSC_SLOW: tick_next = div_wrap;
      SRC_OSC_FAST: tick_next = div_wrap;
      SRC_T0_OVF:   tick_next = tif.t0_ovf;
      SRC_EXT:      tick_next = tif.ext_fall;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  assign tif.tick = tick_reg;

endmodule // ctb_tick_gen

// File: hw/ctb_timebase.sv
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module ctb_timebase
  import ctb_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [WB_DATA_W-1:0]   wb_dat_i,
  output logic      [WB_DATA_W-1:0]   wb_dat_o,
  output logic                        wb_ack_o,
  // Capture/compare module side
  input  wire logic                   timer0_overflow,
  input  wire logic [NUM_MODULES-1:0] module_event,
  input  wire logic [NUM_MODULES-1:0] module_watchdog_req,
  input  wire logic [NUM_MODULES-1:0] module_pin_use,
  input  wire logic [NUM_MODULES-1:0] module_pin_out,
  input  wire logic [NUM_MODULES-1:0] module_pin_drive,
  output logic      [15:0]            count_value,
  output logic      [NUM_MODULES-1:0] module_pin_in,
  output logic                        watchdog_timeout,
  // Port one, bits 7 down to 2
  input  wire logic [PORT_W-1:0]      p1_pin_i,
  output logic      [PORT_W-1:0]      p1_pin_o,
  output logic      [PORT_W-1:0]      p1_pin_oe_n,
  // Interrupt request
  output logic                        array_irq
);

  // Register state
  logic [2:0]             timebase_mode_byte_reg;
  logic                   counter_run_reg;
  logic                   overflow_flag_reg;
  logic [NUM_MODULES-1:0] module_event_flag_reg;
  logic [NUM_MODULES-1:0] module_event_irq_enable_reg;
  logic                   six_clock_reg;
  logic [PORT_W-1:0]      port_out_reg;
  logic [PORT_W-1:0]      port_dir_reg;
  logic [15:0]            count_reg;
  logic [15:0]            count_next;
  logic                   overflow_flag_next;
  logic [NUM_MODULES-1:0] module_event_flag_next;

  // Bus state
  logic                   wb_ack_reg;
  logic [WB_DATA_W-1:0]   wb_dat_reg;
  logic [WB_DATA_W-1:0]   rd_data;
  logic                   wb_req;
  logic                   wr_commit;
  logic                   wr_mode;
  logic                   wr_ctrl;
  logic                   wr_cnt_lo;
  logic                   wr_cnt_hi;
  logic                   wr_ev_en;
  logic                   wr_clk_cfg;
  logic                   wr_port_out;
  logic                   wr_port_dir;

  // Datapath
  logic                   count_step;
  logic                   ovf_event;
  logic                   array_irq_reg;
  logic                   watchdog_reg;
  logic [PORT_W-1:0]      pin_sync;
  logic                   ext_fall;
  logic [PORT_W-1:0]      pin_use_vec;
  logic [PORT_W-1:0]      pin_mod_out_vec;
  logic [PORT_W-1:0]      pin_mod_drv_vec;
  logic [PORT_W-1:0]      pin_o_next;
  logic [PORT_W-1:0]      pin_oe_n_next;
  logic [PORT_W-1:0]      pin_o_reg;
  logic [PORT_W-1:0]      pin_oe_n_reg;

  ctb_tick_if tif ();

  ctb_pin_sync u_pin_sync (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .pin_i      (p1_pin_i),
    .pin_sync_o (pin_sync),
    .ext_fall_o (ext_fall)
  );

  ctb_tick_gen u_tick_gen (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  assign tif.sel       = ctb_src_e'(timebase_mode_byte_reg[MODE_SEL_LSB +: 2]);
  assign tif.six_clock = six_clock_reg;
  assign tif.t0_ovf    = timer0_overflow;
  assign tif.ext_fall  = ext_fall;

  // Wishbone handshake: ack one cycle after the request, writes commit on the ack edge
  assign wb_req    = wb_cyc_i & wb_stb_i;
  assign wr_commit = wb_req & wb_we_i & wb_ack_reg & wb_sel_i[0];
  assign wr_mode     = wr_commit & adr_hit(wb_adr_i, OFS_MODE);
  assign wr_ctrl     = wr_commit & adr_hit(wb_adr_i, OFS_CTRL);
  assign wr_cnt_lo   = wr_commit & adr_hit(wb_adr_i, OFS_CNT_LO);
  assign wr_cnt_hi   = wr_commit & adr_hit(wb_adr_i, OFS_CNT_HI);
  assign wr_ev_en    = wr_commit & adr_hit(wb_adr_i, OFS_EV_IRQ_EN);
  assign wr_clk_cfg  = wr_commit & adr_hit(wb_adr_i, OFS_CLK_CFG);
  assign wr_port_out = wr_commit & adr_hit(wb_adr_i, OFS_PORT_OUT);
  assign wr_port_dir = wr_commit & adr_hit(wb_adr_i, OFS_PORT_DIR);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_reg <= 1'b0;
    end else begin
      wb_ack_reg <= wb_req & ~wb_ack_reg;
    end
  end

  always_comb begin
    rd_data = '0;
    case ({wb_adr_i[ADR_W-1:2], 2'b00})
      OFS_MODE:      rd_data[2:0] = timebase_mode_byte_reg;
      OFS_CTRL:      rd_data[7:0] = {overflow_flag_reg, counter_run_reg, 1'b0, module_event_flag_reg};
      OFS_CNT_LO:    rd_data[7:0] = count_reg[7:0];
      OFS_CNT_HI:    rd_data[7:0] = count_reg[15:8];
      OFS_EV_IRQ_EN: rd_data[NUM_MODULES-1:0] = module_event_irq_enable_reg;
      OFS_CLK_CFG:   rd_data[CLK_SIX_BIT] = six_clock_reg;
      OFS_PORT_OUT:  rd_data[PORT_W-1:0] = port_out_reg;
      OFS_PORT_DIR:  rd_data[PORT_W-1:0] = port_dir_reg;
      OFS_PORT_IN:   rd_data[PORT_W-1:0] = pin_sync;
      default:       rd_data = '0;
    endcase
  end

  // Read data sampled with the request, stable while ack is high
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_reg <= '0;
    end else if (wb_req & ~wb_ack_reg) begin
      wb_dat_reg <= rd_data;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timebase_mode_byte_reg <= RST_MODE;
    end else if (wr_mode) begin
      timebase_mode_byte_reg <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      module_event_irq_enable_reg <= RST_FLAG;
    end else if (wr_ev_en) begin
      module_event_irq_enable_reg <= wb_dat_i[NUM_MODULES-1:0];
    end
  end

  // Clock mode should only change while the counter is stopped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      six_clock_reg <= 1'b0;
    end else if (wr_clk_cfg) begin
      six_clock_reg <= wb_dat_i[CLK_SIX_BIT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      port_out_reg <= RST_PORT;
      port_dir_reg <= RST_PORT;
    end else begin
      if (wr_port_out) begin
        port_out_reg <= wb_dat_i[PORT_W-1:0];
      end
      if (wr_port_dir) begin
        port_dir_reg <= wb_dat_i[PORT_W-1:0];
      end
    end
  end

  // Run control
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counter_run_reg <= 1'b0;
    end else if (wr_ctrl) begin
      counter_run_reg <= wb_dat_i[CTRL_RUN_BIT];
    end
  end

  // Counter; a software load of either byte wins over a step in the same cycle for that byte, the other byte keeps the stepped value
  assign count_step = counter_run_reg & tif.tick;
  assign ovf_event  = count_step & (count_reg == CNT_MAX);

  always_comb begin
    count_next = count_reg;
    if (count_step) begin
      count_next = count_reg + 16'h0001;
    end
    if (wr_cnt_lo) begin
      count_next[7:0] = wb_dat_i[7:0];
    end
    if (wr_cnt_hi) begin
      count_next[15:8] = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= RST_CNT;
    end else begin
      count_reg <= count_next;
    end
  end

  // Flags: hardware only sets, and a set beats a software clear in the same cycle
  always_comb begin
    overflow_flag_next     = wr_ctrl ? wb_dat_i[CTRL_OVF_BIT] : overflow_flag_reg;
    module_event_flag_next = wr_ctrl ? wb_dat_i[NUM_MODULES-1:0] : module_event_flag_reg;
    overflow_flag_next     = overflow_flag_next | ovf_event;
    module_event_flag_next = module_event_flag_next | module_event;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag_reg     <= 1'b0;
      module_event_flag_reg <= RST_FLAG;
    end else begin
      overflow_flag_reg     <= overflow_flag_next;
      module_event_flag_reg <= module_event_flag_next;
    end
  end

  // Interrupt request
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      array_irq_reg <= 1'b0;
    end else begin
      array_irq_reg <= (overflow_flag_reg & timebase_mode_byte_reg[MODE_IRQ_EN_BIT])
                     | (|(module_event_flag_reg & module_event_irq_enable_reg));
    end
  end

  // Watchdog requests from modules that cannot host one are ignored
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_reg <= 1'b0;
    end else begin
      watchdog_reg <= |(module_watchdog_req & WDT_CAPABLE);
    end
  end

  // Pin ownership: a module claims its pin, otherwise the pin is plain I/O
  assign pin_use_vec     = {module_pin_use, 1'b0};
  assign pin_mod_out_vec = {module_pin_out, 1'b0};
  assign pin_mod_drv_vec = {module_pin_drive, 1'b0};

  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pin_use_vec[i]) begin
        pin_o_next[i]    = pin_mod_out_vec[i];
        pin_oe_n_next[i] = ~pin_mod_drv_vec[i];
      end else begin
        pin_o_next[i]    = port_out_reg[i];
        pin_oe_n_next[i] = ~port_dir_reg[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_o_reg    <= RST_PORT;
      pin_oe_n_reg <= '1;
    end else begin
      pin_o_reg    <= pin_o_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  // Outputs
  assign wb_ack_o         = wb_ack_reg;
  assign wb_dat_o         = wb_dat_reg;
  assign count_value      = count_reg;
  assign module_pin_in    = pin_sync[PORT_W-1:MOD0_PIN_IDX];
  assign watchdog_timeout = watchdog_reg;
  assign array_irq        = array_irq_reg;
  assign p1_pin_o         = pin_o_reg;
  assign p1_pin_oe_n      = pin_oe_n_reg;

  // Checks
  a_count_advance: assert property (@(posedge mclk) disable iff (!reset_n)
    count_step && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not advance on a tick");

  a_count_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !counter_run_reg && !wr_cnt_lo && !wr_cnt_hi |=> $stable(count_reg))
    else $error("counter moved while stopped");

  a_overflow_set: assert property (@(posedge mclk) disable iff (!reset_n)
    count_step && count_reg == CNT_MAX && !wr_cnt_lo && !wr_cnt_hi |=> overflow_flag_reg && count_reg == 16'h0000)
    else $error("wrap did not set overflow flag");

  a_overflow_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    overflow_flag_reg && !wr_ctrl |=> overflow_flag_reg)
    else $error("overflow flag cleared by hardware");

  a_module_flag_set: assert property (@(posedge mclk) disable iff (!reset_n)
    |module_event |=> (module_event_flag_reg & $past(module_event)) == $past(module_event))
    else $error("module event did not set its flag");

  a_module_flag_keep: assert property (@(posedge mclk) disable iff (!reset_n)
    !wr_ctrl |=> (module_event_flag_reg & $past(module_event_flag_reg)) == $past(module_event_flag_reg))
    else $error("module flag cleared by hardware");

  a_irq_gated: assert property (@(posedge mclk) disable iff (!reset_n)
    !timebase_mode_byte_reg[MODE_IRQ_EN_BIT] && (module_event_flag_reg & module_event_irq_enable_reg) == '0
    |=> !array_irq)
    else $error("interrupt raised with sources masked");

  a_module_irq: assert property (@(posedge mclk) disable iff (!reset_n)
    (module_event_flag_reg & module_event_irq_enable_reg) != '0 |=> array_irq)
    else $error("enabled module flag gave no interrupt");

  a_timer0_tick: assert property (@(posedge mclk) disable iff (!reset_n)
    tif.sel == SRC_T0_OVF && timer0_overflow |=> tif.tick)
    else $error("timer0 overflow not turned into a tick");

  a_ext_tick: assert property (@(posedge mclk) disable iff (!reset_n)
    tif.sel == SRC_EXT && $fell(pin_sync[EXT_PIN_IDX]) |=> tif.tick)
    else $error("external falling edge not counted");

  a_watchdog_m4: assert property (@(posedge mclk) disable iff (!reset_n)
    !module_watchdog_req[NUM_MODULES-1] |=> !watchdog_timeout)
    else $error("watchdog from a module without it");

  a_pin_route: assert property (@(posedge mclk) disable iff (!reset_n)
    module_pin_use[0] && module_pin_drive[0] |=> !p1_pin_oe_n[MOD0_PIN_IDX]
    && p1_pin_o[MOD0_PIN_IDX] == $past(module_pin_out[0]))
    else $error("module zero pin not routed");

  a_pin_gpio: assert property (@(posedge mclk) disable iff (!reset_n)
    !module_pin_use[0] |=> p1_pin_o[MOD0_PIN_IDX] == $past(port_out_reg[MOD0_PIN_IDX]))
    else $error("free pin lost its port value");

endmodule // ctb_timebase

// File: verification/ctb_pin_model.sv
`timescale 1ns/1ps
module ctb_pin_model
  import ctb_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Design side of port one
  input  wire logic [PORT_W-1:0] pin_o,
  input  wire logic [PORT_W-1:0] pin_oe_n,
  // Resolved pin levels
  output logic      [PORT_W-1:0] pin_level
);
  logic ext_level;

  initial begin
    ext_level = 1'b1;
  end

  // Pull-ups hold released pins high, except the external pin, which follows ext_level, so a stale value never lingers
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pin_oe_n[i] === 1'b0)
        pin_level[i] = pin_o[i];
      else if (i == EXT_PIN_IDX)
        pin_level[i] = ext_level;
      else
        pin_level[i] = 1'b1;
    end
  end

  // Each level held at least four cycles keeps the input at or below /8
  task automatic ext_pulses(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge mclk);
      ext_level <= 1'b0;
      repeat (half) @(posedge mclk);
      ext_level <= 1'b1;
    end
  endtask
endmodule // ctb_pin_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ctb_pkg::*;
  logic                   mclk;
  logic                   reset_n;
  logic                   cyc;
  logic                   stb;
  logic                   we;
  logic [ADR_W-1:0]       adr;
  logic [WB_DATA_W-1:0]   wdat;
  logic [WB_DATA_W-1:0]   rdat;
  logic                   ack;
  logic                   t0_ovf;
  logic [NUM_MODULES-1:0] mev;
  logic [NUM_MODULES-1:0] wd_req;
  logic [NUM_MODULES-1:0] pin_use;
  logic [NUM_MODULES-1:0] pin_out;
  logic [NUM_MODULES-1:0] pin_drv;
  logic [15:0]            cnt;
  logic [NUM_MODULES-1:0] pin_in;
  logic                   wd_out;
  logic [PORT_W-1:0]      pin_i;
  logic [PORT_W-1:0]      pin_o;
  logic [PORT_W-1:0]      pin_oe_n;
  logic                   irq;
  logic [7:0]             q;
  int                     errors;
  int                     compares;
  int                     divs[4] = '{12, 4, 6, 2};

  ctb_timebase dut_u (
    .mclk(mclk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer0_overflow(t0_ovf), .module_event(mev), .module_watchdog_req(wd_req),
    .module_pin_use(pin_use), .module_pin_out(pin_out), .module_pin_drive(pin_drv),
    .count_value(cnt), .module_pin_in(pin_in), .watchdog_timeout(wd_out),
    .p1_pin_i(pin_i), .p1_pin_o(pin_o), .p1_pin_oe_n(pin_oe_n), .array_irq(irq)
  );

  ctb_pin_model pm_u (
    .mclk(mclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_level(pin_i)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic cycle; ack and read data are taken at the edge that samples ack high
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      $display("mismatch wb_ack expected 1 seen %b", ack);
      errors++;
      complete_run();
    end else begin
      q   = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask

  task automatic rd(input logic [ADR_W-1:0] a, input string name, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    check(name, {8'h00, q}, {8'h00, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic pulse_t0();
    @(posedge mclk);
    t0_ovf <= 1'b1;
    @(posedge mclk);
    t0_ovf <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    $display("mismatch run_length expected finish seen hang");
    errors++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    {cyc, stb, we, t0_ovf} = 4'h0;
    adr = '0;
    wdat = '0;
    {mev, wd_req, pin_use, pin_out, pin_drv} = '0;
    errors = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFS_MODE, "mode", 8'h00);
    rd(OFS_CTRL, "ctrl", 8'h00);
    rd(OFS_CNT_LO, "count_lo", 8'h00);
    rd(OFS_CNT_HI, "count_hi", 8'h00);
    rd(6'h3C, "unmapped", 8'h00);
    $display("test reset done");
    // Timer0 source across the wrap, then halted
    wb(1'b1, OFS_MODE, 8'h04);
    wb(1'b1, OFS_CNT_HI, 8'hFF);
    wb(1'b1, OFS_CNT_LO, 8'hFD);
    wb(1'b1, OFS_CTRL, 8'h40);
    repeat (3) pulse_t0();
    settle(3);
    rd(OFS_CTRL, "ctrl", 8'hC0);
    rd(OFS_CNT_LO, "count_lo", 8'h00);
    rd(OFS_CNT_HI, "count_hi", 8'h00);
    check("array_irq", irq, 16'h0);
    wb(1'b1, OFS_MODE, 8'h05);
    settle(2);
    check("array_irq", irq, 16'h1);
    wb(1'b1, OFS_CTRL, 8'h80);
    repeat (2) pulse_t0();
    settle(3);
    rd(OFS_CNT_LO, "count_lo", 8'h00);
    rd(OFS_CTRL, "ctrl", 8'h80);
    wb(1'b1, OFS_CTRL, 8'h00);
    settle(2);
    check("array_irq", irq, 16'h0);
    $display("test overflow done");
    wb(1'b1, OFS_MODE, 8'h00);
    for (int i = 0; i < NUM_MODULES; i++) begin
      @(posedge mclk);
      mev <= 5'h01 << i;
      @(posedge mclk);
      mev <= 5'h00;
      rd(OFS_CTRL, "ctrl", 8'((2 << i) - 1));
    end
    check("array_irq", irq, 16'h0);
    wb(1'b1, OFS_EV_IRQ_EN, 8'h04);
    settle(2);
    check("array_irq", irq, 16'h1);
    wb(1'b1, OFS_CTRL, 8'h00);
    settle(2);
    check("array_irq", irq, 16'h0);
    $display("test module flags done");
    // About 98 cycles of run between the two control commits
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, OFS_CLK_CFG, {7'h00, k[1]});
      wb(1'b1, OFS_MODE, {6'h00, k[0], 1'b0});
      wb(1'b1, OFS_CNT_LO, 8'h00);
      wb(1'b1, OFS_CTRL, 8'h40);
      repeat (96) @(posedge mclk);
      wb(1'b1, OFS_CTRL, 8'h00);
      wb(1'b0, OFS_CNT_LO, 8'h00);
      check("tick_rate", 16'(q >= 98 / divs[k] - 1 && q <= 98 / divs[k] + 1), 16'h1);
      check("count_value", cnt, {8'h00, q});
    end
    $display("test oscillator done");
    wb(1'b1, OFS_CLK_CFG, 8'h00);
    wb(1'b1, OFS_MODE, 8'h06);
    wb(1'b1, OFS_CNT_LO, 8'h00);
    wb(1'b1, OFS_CTRL, 8'h40);
    pm_u.ext_pulses(5, 4);
    settle(8);
    rd(OFS_CNT_LO, "count_lo", 8'h05);
    $display("test external done");
    @(posedge mclk);
    wd_req <= 5'h10;
    settle(2);
    check("watchdog_timeout", wd_out, 16'h1);
    @(posedge mclk);
    wd_req <= 5'h08;
    settle(2);
    check("watchdog_timeout", wd_out, 16'h0);
    @(posedge mclk);
    {pin_use, pin_out, pin_drv} <= {5'h01, 5'h01, 5'h01};
    wb(1'b1, OFS_PORT_DIR, 8'h20);
    wb(1'b1, OFS_PORT_OUT, 8'h00);
    settle(4);
    check("p1_pin_oe_n", pin_oe_n, 16'h1D);
    check("p1_pin_o", pin_o & 6'h22, 16'h02);
    check("module_pin_in", pin_in, 16'h0F);
    rd(OFS_PORT_IN, "port_in", 8'h1F);
    $display("test pins done");
    // Reset while the counter runs on the external source
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFS_MODE, "mode", 8'h00);
    rd(OFS_CTRL, "ctrl", 8'h00);
    rd(OFS_CNT_LO, "count_lo", 8'h00);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // tb_top
